// ---- hdl/fpm_pkg.sv ----
package fpm_pkg;

   // ------------------------------------------------------------
   // address map
   // ------------------------------------------------------------
   localparam int ADDR_W = 24;
   localparam logic [23:0] FLASH_TOP = 24'h0bffff;
   localparam logic [23:0] BOOT_PLANE_SIZE = 24'h002000;
   localparam logic [23:0] SMALL_BLOCKS_END = 24'h008000;
   localparam logic [23:0] MID_BLOCK_END = 24'h010000;
   localparam int UNIT_LSB = 7;
   localparam logic [4:0] MID_BLOCK_NUM = 5'h08;
   localparam logic [7:0] UNDEF_FILL = 8'hff;

   // ------------------------------------------------------------
   // mode pin codes and reset values
   // ------------------------------------------------------------
   localparam logic [2:0] PIN_USER = 3'h7;
   localparam logic [2:0] PIN_USER_BOOT = 3'h6;
   localparam logic [2:0] PIN_BOOT = 3'h2;
   localparam logic [2:0] PIN_PROGRAMMER = 3'h1;
   localparam logic [2:0] PIN_RESET_VAL = 3'h7;

   typedef enum logic [2:0] {
      md_user = 3'b000,
      md_user_prog = 3'b001,
      md_user_boot = 3'b010,
      md_boot = 3'b011,
      md_programmer = 3'b100,
      md_no_flash = 3'b101
   } fpm_mode_type;

   typedef enum logic [1:0] {
      pl_user = 2'b00,
      pl_boot = 2'b01,
      pl_embedded = 2'b10
   } fpm_plane_type;

   typedef enum logic [2:0] {
      st_vec = 3'b000,
      st_run = 3'b001,
      st_erase_all = 3'b010,
      st_erase_blk = 3'b011,
      st_prog = 3'b100
   } fpm_state_type;

   // command held towards the flash array while an operation runs
   typedef struct packed {
      logic valid;
      logic erase;
      logic all;
      fpm_plane_type plane;
      logic [23:0] addr;
      logic [4:0] block;
   } fpm_cmd_type;

   // one cpu bus access
   typedef struct packed {
      logic req;
      logic we;
      logic [23:0] addr;
   } fpm_bus_type;

endpackage

// ---- hdl/fpm_erase_map.sv ----
`timescale 1ns/1ps
`default_nettype none

// maps a user plane address onto its erase block number
module fpm_erase_map
   import fpm_pkg::*;
(
   input wire logic [23:0] addr,
   output logic [4:0] block,
   output logic small_block,
   output logic in_plane
);

   // -----------------------------------------------------------
   // block decode: 8 x 4k, 1 x 32k, 11 x 64k
   // -----------------------------------------------------------
   always_comb begin
      small_block = addr < SMALL_BLOCKS_END;
      in_plane = addr <= FLASH_TOP;
      if (small_block) begin
         block = {2'b00, addr[14:12]};
      end else if (addr < MID_BLOCK_END) begin
         block = MID_BLOCK_NUM;
      end else begin
         // 64k blocks follow on from the 32k block 8, starting at block 9
         block = 5'(MID_BLOCK_NUM + {1'b0, addr[19:16]});
      end
   end

endmodule

`default_nettype wire

// ---- hdl/fpm_flash_plane.sv ----
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - both planes share base, plane select picks
// - boot plane writable only boot/programmer mode
// - boot plane reads past 8k undefined
// - user mode reads only, never programs
// - program in 128-byte aligned units
// - erase blocks: 8x4k, 32k, 11x64k
// - ram overlay only over 4k blocks
// - plane decoded 000000-0bffff in modes 1,2,6,7
// - reset plane follows the operating mode
// - user boot vectors embedded first, then plane
// - boot mode erases all before its first block erase after reset
// - mode taken from pins held in reset
module fpm_flash_plane
   import fpm_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [2:0] mode_pins,
   input wire logic sw_prog_on,
   input wire logic regs_checked,
   input wire logic ps_wr,
   input wire logic ps_boot,
   input wire fpm_bus_type bus,
   output logic bus_ack,
   output logic [7:0] bus_rdata,
   input wire logic op_valid,
   input wire logic op_erase,
   input wire logic [23:0] op_addr,
   output logic op_ready,
   output logic op_refused,
   input wire logic emul_en,
   input wire logic [7:0] ram_rdata,
   output logic ram_sel,
   output fpm_plane_type rd_plane,
   output logic [23:0] rd_addr,
   input wire logic [7:0] arr_rdata,
   output fpm_cmd_type arr_cmd,
   input wire logic arr_done,
   output fpm_mode_type mode,
   output logic plane_select_register
);

   // -----------------------------------------------------------
   // mode pin synchroniser
   // -----------------------------------------------------------
   logic [2:0] pin_s1, pin_s2, pin_s3, pin_stable;
   logic [2:0] next_pin_stable;

   // the stable copy moves only when stages two and three agree
   always_comb begin
      next_pin_stable = pin_stable;
      if (pin_s2 == pin_s3) begin
         next_pin_stable = pin_s3;
      end
   end

   always_ff @(posedge clk) begin
      pin_s1 <= mode_pins;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_stable <= next_pin_stable;
   end

   // -----------------------------------------------------------
   // operating mode
   // -----------------------------------------------------------
   fpm_mode_type pin_mode, next_mode;

   function automatic fpm_mode_type decode_pins(input logic [2:0] p);
      unique case (p)
         PIN_USER: decode_pins = md_user;
         PIN_USER_BOOT: decode_pins = md_user_boot;
         PIN_BOOT: decode_pins = md_boot;
         PIN_PROGRAMMER: decode_pins = md_programmer;
         default: decode_pins = md_no_flash;
      endcase
   endfunction

   // pins are sampled through reset, frozen on release, so a pin
   // change alone never leaves a boot mode; decoding the agreed
   // value directly lets a four-cycle reset settle the mode
   always_comb begin
      pin_mode = decode_pins(next_pin_stable);
      next_mode = mode;
      if (srst) begin
         next_mode = pin_mode;
      end else if (mode == md_user && sw_prog_on) begin
         next_mode = md_user_prog;
      end else if (mode == md_user_prog && !sw_prog_on) begin
         next_mode = md_user;
      end
   end

   always_ff @(posedge clk) begin
      mode <= next_mode;
   end

   // -----------------------------------------------------------
   // sequencer, plane select and command register
   // -----------------------------------------------------------
   fpm_state_type state, next_state;
   fpm_cmd_type next_cmd;
   logic next_ps, all_erased, next_all_erased, next_refused;
   logic [4:0] op_block;
   logic op_small, op_in_plane, allowed;

   fpm_erase_map u_map (
      .addr(op_addr),
      .block(op_block),
      .small_block(op_small),
      .in_plane(op_in_plane)
   );

   assign op_ready = state == st_run;

   // which modes may touch which plane
   always_comb begin
      unique case (mode)
         md_boot, md_programmer: allowed = op_in_plane;
         md_user_prog, md_user_boot: allowed = op_in_plane
            && !plane_select_register;
         default: allowed = 1'b0;
      endcase
   end

   always_comb begin
      next_state = state;
      next_cmd = arr_cmd;
      next_ps = plane_select_register;
      next_all_erased = all_erased;
      next_refused = 1'b0;
      if (ps_wr) begin
         next_ps = ps_boot;
      end
      unique case (state)
         st_vec: begin
            // embedded vector until registers are checked
            if (regs_checked || mode == md_user
                || mode == md_user_prog || mode == md_no_flash) begin
               next_state = st_run;
            end
         end
         st_run: begin
            if (op_valid && !allowed) begin
               next_refused = 1'b1;
            end else if (op_valid) begin
               next_cmd.valid = 1'b1;
               next_cmd.erase = op_erase;
               next_cmd.all = 1'b0;
               next_cmd.plane = plane_select_register ? pl_boot : pl_user;
               next_cmd.addr = {op_addr[23:UNIT_LSB],
                                {UNIT_LSB{1'b0}}};
               next_cmd.block = op_block;
               if (!op_erase) begin
                  next_state = st_prog;
               end else if (mode == md_boot && !all_erased) begin
                  next_cmd.all = 1'b1;
                  next_state = st_erase_all;
               end else begin
                  next_state = st_erase_blk;
               end
            end
         end
         st_erase_all: begin
            if (arr_done) begin
               next_all_erased = 1'b1;
               next_cmd.all = 1'b0;
               next_state = st_erase_blk;
            end
         end
         st_erase_blk, st_prog: begin
            if (arr_done) begin
               next_cmd.valid = 1'b0;
               next_state = st_run;
            end
         end
         default: next_state = st_run;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state <= st_vec;
         arr_cmd <= '0;
         all_erased <= 1'b0;
         op_refused <= 1'b0;
         // user boot mode starts on the boot plane
         plane_select_register <= pin_mode == md_user_boot;
      end else begin
         state <= next_state;
         arr_cmd <= next_cmd;
         all_erased <= next_all_erased;
         op_refused <= next_refused;
         plane_select_register <= next_ps;
      end
   end

   // -----------------------------------------------------------
   // read path
   // -----------------------------------------------------------
   logic flash_mode, hit, boot_over, next_ack;
   logic [7:0] next_rdata;

   // the array read is combinational; only the answer is stored
   always_comb begin
      flash_mode = mode != md_no_flash;
      hit = flash_mode && bus.addr <= FLASH_TOP;
      rd_addr = bus.addr;
      if (state == st_vec) begin
         rd_plane = pl_embedded;
      end else begin
         rd_plane = plane_select_register ? pl_boot : pl_user;
      end
      boot_over = rd_plane == pl_boot && bus.addr >= BOOT_PLANE_SIZE;
      // overlay limited to the small blocks keeps big blocks honest
      ram_sel = emul_en && hit && rd_plane == pl_user
         && bus.addr < SMALL_BLOCKS_END
         && (mode == md_user_prog || mode == md_user_boot);
      next_ack = bus.req;
      next_rdata = 8'h00;
      if (bus.req && !bus.we && hit) begin
         if (ram_sel) begin
            next_rdata = ram_rdata;
         end else if (boot_over) begin
            next_rdata = UNDEF_FILL;
         end else begin
            next_rdata = arr_rdata;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         bus_ack <= 1'b0;
         bus_rdata <= 8'h00;
      end else begin
         bus_ack <= next_ack;
         bus_rdata <= next_rdata;
      end
   end

   // -----------------------------------------------------------
   // checks
   // -----------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   chk_plane_route: assert property (
      ps_wr |=> plane_select_register == $past(ps_boot))
      else $error("plane select did not follow its write");
   chk_boot_guard: assert property (
      arr_cmd.valid && arr_cmd.plane == pl_boot
      |-> mode == md_boot || mode == md_programmer)
      else $error("boot plane written in wrong mode");
   chk_undef_fill: assert property (
      bus.req && !bus.we && hit && boot_over && !ram_sel
      |=> bus_ack && bus_rdata == UNDEF_FILL)
      else $error("boot plane overrun not filled");
   chk_user_block: assert property (
      op_valid && op_ready && (mode == md_user || mode == md_no_flash)
      |=> op_refused && !arr_cmd.valid)
      else $error("user mode operation not refused");
   chk_unit_align: assert property (
      arr_cmd.valid |-> arr_cmd.addr[6:0] == 7'h00)
      else $error("program unit not aligned");
   chk_emul_range: assert property (
      ram_sel |-> bus.addr < SMALL_BLOCKS_END)
      else $error("overlay outside small blocks");
   chk_map_top: assert property (
      bus.req && !bus.we && bus.addr > FLASH_TOP |=> bus_rdata == 8'h00)
      else $error("address above plane answered");
   chk_erase_first: assert property (
      $rose(arr_cmd.valid) && arr_cmd.erase && mode == md_boot
      && !$past(all_erased) |-> arr_cmd.all)
      else $error("boot erase skipped erase of all");
   chk_vec_wait: assert property (
      state == st_vec && mode == md_user_boot && !regs_checked
      |=> state == st_vec)
      else $error("boot vector left before check");
   chk_write_ign: assert property (
      $rose(arr_cmd.valid) |-> $past(op_valid) && $past(op_ready))
      else $error("array command without operation");

endmodule

`default_nettype wire

// ---- verification/fpm_array_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// flash array stand-in: fixed contents, slow program/erase steps
// ------------------------------------------------------------
module fpm_array_model
   import fpm_pkg::*;
#(
   parameter int STEP_CYC = 3
)(
   input wire logic clk,
   input wire fpm_plane_type rd_plane,
   input wire logic [23:0] rd_addr,
   input wire fpm_cmd_type arr_cmd,
   output logic [7:0] arr_rdata,
   output logic arr_done
);
   int cnt = 0;

   // contents differ per plane so a wrong plane choice shows at once
   assign arr_rdata = {rd_plane, 6'h00} ^ rd_addr[7:0];

   // each step takes a fixed time; restart after every done pulse
   initial arr_done = 1'b0;
   always @(posedge clk) begin
      arr_done <= 1'b0;
      if (arr_cmd.valid !== 1'b1 || arr_done) begin
         cnt <= 0;
      end else if (cnt == STEP_CYC - 1) begin
         arr_done <= 1'b1;
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule

`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top
   import fpm_pkg::*;
();
   logic clk, srst, sw_prog_on, regs_checked, ps_wr, ps_boot;
   logic op_valid, op_erase, emul_en, bus_ack, op_ready, op_refused;
   logic ram_sel, plane_select_register, arr_done;
   logic [2:0] mode_pins;
   logic [23:0] op_addr, rd_addr;
   logic [7:0] ram_rdata, bus_rdata, arr_rdata;
   fpm_bus_type bus;
   fpm_plane_type rd_plane;
   fpm_cmd_type arr_cmd, first, last;
   fpm_mode_type mode;
   int mismatches = 0;
   int n_tests = 0;
   int cyc = 0;

   fpm_flash_plane DUT (
      .clk, .srst, .mode_pins, .sw_prog_on, .regs_checked, .ps_wr,
      .ps_boot, .bus, .bus_ack, .bus_rdata, .op_valid, .op_erase,
      .op_addr, .op_ready, .op_refused, .emul_en, .ram_rdata, .ram_sel,
      .rd_plane, .rd_addr, .arr_rdata, .arr_cmd, .arr_done, .mode,
      .plane_select_register
   );

   fpm_array_model #(.STEP_CYC(3)) u_array (
      .clk, .rd_plane, .rd_addr, .arr_cmd, .arr_rdata, .arr_done
   );

   // ------------------------------------------------------------
   // clock and hang guard
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // under two hundred cycles suffice; far beyond that means a hang
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         final_report();
      end
   end

   // ------------------------------------------------------------
   // shared helpers
   // ------------------------------------------------------------
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   // inputs always move 1 ns after the rising edge
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic rst(logic [2:0] p, fpm_mode_type m);
      {srst, mode_pins} = {1'b1, p};
      tick(4);
      srst = 1'b0;
      check("mode", m, mode);
      tick(2);
   endtask

   // one bus access; req dropped a cycle apart so no double drive
   task automatic acc(logic we, logic [23:0] a, logic [7:0] exp);
      bus = '{1'b1, we, a};
      tick(1);
      check("bus_ack", 1, bus_ack);
      if (!we) check("bus_rdata", exp, bus_rdata);
      bus.req = 1'b0;
      tick(1);
   endtask

   task automatic sel(logic b);
      {ps_wr, ps_boot} = {1'b1, b};
      tick(1);
      ps_wr = 1'b0;
      check("plane_select_register", b, plane_select_register);
   endtask

   // issue one operation, keep the first and last array command seen
   task automatic op(logic er, logic [23:0] a, logic refused);
      int k = 0;
      while (op_ready !== 1'b1 && k < 50) begin
         tick(1);
         k++;
      end
      check("op_ready", 1, op_ready);
      {op_valid, op_erase, op_addr} = {1'b1, er, a};
      tick(1);
      op_valid = 1'b0;
      check("op_refused", refused, op_refused);
      check("arr_cmd.valid", !refused, arr_cmd.valid);
      first = arr_cmd;
      last = arr_cmd;
      while (arr_cmd.valid === 1'b1 && k < 300) begin
         last = arr_cmd;
         tick(1);
         k++;
      end
      check("arr_cmd.valid done", 0, arr_cmd.valid);
      tick(1);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_user;
      rst(PIN_USER, md_user);
      check("plane_select_register", 0, plane_select_register);
      acc(0, 24'h000123, 8'h23);
      acc(0, 24'h0bff5a, 8'h5a);
      acc(0, 24'h0c0000, 8'h00);
      acc(1, 24'h000040, 8'h00);
      check("arr_cmd.valid", 0, arr_cmd.valid);
      acc(0, 24'h000040, 8'h40);
      op(1, 24'h001000, 1);
   endtask

   task automatic t_prog;
      sw_prog_on = 1'b1;
      tick(2);
      check("mode", md_user_prog, mode);
      op(0, 24'h000181, 0);
      check("prog addr", 24'h000180, last.addr);
      check("prog erase", 0, last.erase);
      sel(1);
      op(1, 24'h000100, 1);
      sw_prog_on = 1'b0;
      acc(0, 24'h000010, 8'h50);
      acc(0, 24'h001fff, 8'hbf);
      acc(0, 24'h002000, 8'hff);
      sel(0);
   endtask

   task automatic t_boot;
      logic [23:0] ta [6] = '{24'h000000, 24'h007fff, 24'h008000,
                              24'h00ffff, 24'h010000, 24'h0bffff};
      logic [4:0] blk [6] = '{5'h00, 5'h07, 5'h08, 5'h08, 5'h09, 5'h13};
      rst(PIN_BOOT, md_boot);
      acc(0, 24'h000011, 8'h91);
      regs_checked = 1'b1;
      tick(2);
      op(1, 24'h009000, 0);
      check("first all", 1, first.all);
      check("last all", 0, last.all);
      check("block", 8, last.block);
      for (int i = 0; i < 6; i++) begin
         op(1, ta[i], 0);
         check("first all", 0, first.all);
         check("block", blk[i], last.block);
      end
      sel(1);
      op(0, 24'h0010ff, 0);
      check("prog plane", pl_boot, last.plane);
      check("prog addr", 24'h001080, last.addr);
      op(0, 24'h0c0000, 1);
      regs_checked = 1'b0;
   endtask

   task automatic t_uboot;
      rst(PIN_USER_BOOT, md_user_boot);
      check("plane_select_register", 1, plane_select_register);
      acc(0, 24'h000022, 8'ha2);
      regs_checked = 1'b1;
      tick(2);
      acc(0, 24'h000022, 8'h62);
      op(1, 24'h000000, 1);
      sel(0);
      {emul_en, ram_rdata} = {1'b1, 8'h5a};
      acc(0, 24'h007ffe, 8'h5a);
      check("ram_sel", 1, ram_sel);
      acc(0, 24'h008001, 8'h01);
      check("ram_sel", 0, ram_sel);
      {emul_en, regs_checked} = 2'b00;
      // a pin change without reset must not leave user boot mode
      mode_pins = PIN_USER;
      tick(6);
      check("mode", md_user_boot, mode);
   endtask

   // unmapped pin code, then the off-board programming mode
   task automatic t_other;
      rst(3'h0, md_no_flash);
      acc(0, 24'h000123, 8'h00);
      op(1, 24'h001000, 1);
      rst(PIN_PROGRAMMER, md_programmer);
      regs_checked = 1'b1;
      sel(1);
      op(0, 24'h000005, 0);
      check("prog plane", pl_boot, last.plane);
      check("prog addr", 24'h000000, last.addr);
      regs_checked = 1'b0;
   endtask

   // ------------------------------------------------------------
   // main sequence and verdict
   // ------------------------------------------------------------
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      {sw_prog_on, regs_checked, ps_wr, ps_boot} = 4'h0;
      {op_valid, op_erase, emul_en, op_addr, ram_rdata} = '0;
      bus = '0;
      t_user();
      t_prog();
      t_boot();
      t_uboot();
      t_other();
      rst(PIN_USER, md_user);
      check("plane_select_register", 0, plane_select_register);
      final_report();
   end
endmodule

`default_nettype wire
